// file: src/acs_sequencer.sv
// Purpose: successive-approximation conversion sequencer, AHB-Lite slave
// Assumes: hclk is Tosc; cmp_decision comes from hclk-timed comparator
// Notes:   result bytes have no reset
`timescale 1ns/1ps
// Overview of operation
// - a conversion spans twelve bit periods (thirteen at 2 Tosc) before result and busy clear
// - clock select picks 2,4,8,16,32,64 Tosc or the RC clock
// - channel select and pin direction never block a conversion
// - analog-configured pins read as zero on the port
// - clearing busy aborts at once; result bytes keep old value
// - after abort acquisition resumes and a new start is accepted
// - first segment lasts at least one instruction cycle, then ends at the next bit tick
// - result is justified into sixteen bits, unused bits zero
// - result bytes are plain read-write storage when not converting
// - sleep conversion needs RC; RC start waits one instruction cycle
// - finish in sleep loads result, wakes if enabled, else powers down
// - sleep with divided clock aborts and powers down, enable stays set
// - reset clears control, powers off, aborts, makes pins analog
// - result bytes are not touched by any reset
// - completion loads result, clears busy, sets the done flag
// - justify set: high six bits zero; clear: low six bits zero
module acs_sequencer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        rc_clk,
	input  wire logic [7:0]  port_pins,
	input  wire logic        sleep_mode,
	input  wire logic        cmp_decision,
	output logic [9:0]       dac_code,
	output logic [2:0]       channel_select,
	output logic             analog_power,
	output logic             acquire_en,
	output logic [7:0]       pin_analog_config,
	output logic             wake_req,
	output logic             irq_req
);
	typedef enum logic [1:0] {S_IDLE, S_FIRST, S_CONV} acs_state_e;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	acs_state_e  state_r;
	acs_state_e  state_nxt;
	logic [7:0]  ctrl_r;
	logic [7:0]  fmt_r;
	logic [3:0]  stat_r;
	logic        go_r;
	logic        down_r;
	logic [9:0]  trial_r;
	logic [9:0]  trial_nxt;
	logic [3:0]  tad_cnt_r;
	logic [2:0]  first_cnt_r;
	logic [7:0]  res_hi_r;
	logic [7:0]  res_lo_r;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [7:0]  idx_r;
	logic [2:0]  rc_sync_r;
	logic        rc_lvl_r;
	logic [7:0]  pin_s1_r;
	logic [7:0]  pin_s2_r;
	logic [7:0]  pin_s3_r;
	logic [7:0]  pin_lvl_r;
	logic [7:0]  port_rd_r;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire        accept   = hsel && hready && htrans[1];
	wire [7:0]  wdata    = hwdata[7:0];
	wire        wr_ctrl  = wr_pend_r && (idx_r == acs_pkg::IDX_CONTROL);
	wire        wr_fmt   = wr_pend_r && (idx_r == acs_pkg::IDX_FORMAT);
	wire        wr_hi    = wr_pend_r && (idx_r == acs_pkg::IDX_RES_HIGH);
	wire        wr_lo    = wr_pend_r && (idx_r == acs_pkg::IDX_RES_LOW);
	wire        wr_stat  = wr_pend_r && (idx_r == acs_pkg::IDX_STATUS);
	wire [2:0]  clk_sel  = {fmt_r[acs_pkg::FP_CLK_HI], ctrl_r[acs_pkg::CM_CLK_MID],
	                        ctrl_r[acs_pkg::CM_CLK_LO]};
	wire        rc_sel   = (clk_sel[1:0] == acs_pkg::SEL_RC);
	wire        justify  = fmt_r[acs_pkg::FP_JUSTIFY];
	wire        pwr_on   = ctrl_r[acs_pkg::CM_PWR];
	wire [7:0]  ctrl_rd  = {ctrl_r[7:3], go_r, 1'b0, ctrl_r[0]};
	wire [7:0]  stat_rd  = {3'b000, analog_power, stat_r};

	// ------------------------------------------------------------
	// conversion control
	// ------------------------------------------------------------
	logic tad_tick;
	logic [7:0] analog_mask;
	logic [7:0] port_read;

	wire start_req = wr_ctrl && wdata[acs_pkg::CM_GO] && wdata[acs_pkg::CM_PWR] && pwr_on
	                 && !go_r && !down_r && !(sleep_mode && !rc_sel);
	wire abort_sw  = go_r && wr_ctrl && !(wdata[acs_pkg::CM_GO] && wdata[acs_pkg::CM_PWR]);
	wire abort_slp = go_r && sleep_mode && !rc_sel;
	wire abort     = abort_sw || abort_slp;
	wire last_tad  = (state_r == S_CONV) && tad_tick && (tad_cnt_r == acs_pkg::TAD_LAST);
	wire done      = last_tad && !abort;
	wire wake_en   = stat_r[acs_pkg::ST_DONE_IE] && stat_r[acs_pkg::ST_PERI_IE];
	// first segment holds one instruction cycle
	wire first_ok  = (first_cnt_r == acs_pkg::TCY_LAST);
	wire bit_step  = (state_r == S_CONV) && tad_tick && (tad_cnt_r != acs_pkg::TAD_LAST);
	wire [3:0] bit_pos = 4'(4'd10 - tad_cnt_r);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE:  if (start_req) state_nxt = S_FIRST;
			// rc start also waits one instruction cycle
			S_FIRST: if (first_ok && tad_tick) state_nxt = S_CONV;
			S_CONV:  if (last_tad) state_nxt = S_IDLE;
		endcase
		if (abort) state_nxt = S_IDLE;
	end

	// successive approximation: keep or drop bit, then try next lower bit
	always_comb begin
		trial_nxt = trial_r;
		for (int i = 0; i < acs_pkg::RES_W; i++) begin
			if (bit_step && (bit_pos == 4'(i))) trial_nxt[i] = cmp_decision;
		end
		for (int i = 1; i < acs_pkg::RES_W; i++) begin
			if (bit_step && (bit_pos == 4'(i))) trial_nxt[i-1] = 1'b1;
		end
		if (start_req) trial_nxt = acs_pkg::SAR_FIRST;
	end

	wire [7:0] load_hi = justify ? {6'h00, trial_r[9:8]} : trial_r[9:2];
	wire [7:0] load_lo = justify ? trial_r[7:0] : {trial_r[1:0], 6'h00};

	acs_tad_gen u_tad (
		.hclk    (hclk),
		.hresetn (hresetn),
		.sel     (clk_sel),
		.rc_edge ((rc_sync_r[2] == rc_sync_r[1]) && rc_sync_r[1] && !rc_lvl_r),
		.restart (start_req),
		.tick    (tad_tick)
	);

	acs_pin_mask u_pins (
		.pcfg        (fmt_r[acs_pkg::FP_PCFG_HI:0]),
		.port_lvl    (pin_lvl_r),
		.analog_mask (analog_mask),
		.port_read   (port_read)
	);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire [7:0] rd_byte =
		(idx_r == acs_pkg::IDX_RES_HIGH) ? res_hi_r :
		(idx_r == acs_pkg::IDX_RES_LOW)  ? res_lo_r :
		(idx_r == acs_pkg::IDX_CONTROL)  ? ctrl_rd  :
		(idx_r == acs_pkg::IDX_FORMAT)   ? {fmt_r[7:6], 2'b00, fmt_r[3:0]} :
		(idx_r == acs_pkg::IDX_STATUS)   ? stat_rd  :
		(idx_r == acs_pkg::IDX_PORT)     ? port_rd_r : 8'h00;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			idx_r     <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_pend_r <= accept && hwrite;
			rd_pend_r <= accept && !hwrite;
			if (accept) idx_r <= (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'hff;
			hreadyout <= !(accept && !hwrite);
			hresp     <= 1'b0;
			if (rd_pend_r) hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	// reset clears control and aborts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= S_IDLE;
			ctrl_r      <= acs_pkg::CONTROL_RST;
			fmt_r       <= acs_pkg::FORMAT_RST;
			go_r        <= 1'b0;
			trial_r     <= 10'h000;
			tad_cnt_r   <= 4'h0;
			first_cnt_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			trial_r <= trial_nxt;
			if (wr_ctrl) ctrl_r <= wdata & ~8'h06;
			if (wr_fmt)  fmt_r  <= wdata & 8'hcf;
			go_r <= (start_req || go_r) && !abort && !done;
			if (start_req) first_cnt_r <= 3'h0;
			else if (!first_ok) first_cnt_r <= 3'(first_cnt_r + 3'd1);
			if (state_r != S_CONV) tad_cnt_r <= 4'h1;
			else if (tad_tick) tad_cnt_r <= 4'(tad_cnt_r + 4'd1);
		end
	end

	// finish in sleep without wake powers down
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			down_r <= 1'b0;
			stat_r <= acs_pkg::STATUS_RST;
		end else begin
			down_r <= sleep_mode && (down_r || !rc_sel || (done && !wake_en));
			// flag sets regardless of enables, set wins
			stat_r[acs_pkg::ST_FLAG] <= done ||
				(wr_stat ? wdata[acs_pkg::ST_FLAG] : stat_r[acs_pkg::ST_FLAG]);
			if (wr_stat) stat_r[3:1] <= wdata[3:1];
		end
	end

	// software write when no result lands
	always_ff @(posedge hclk) begin
		if (done) begin
			res_hi_r <= load_hi;
			res_lo_r <= load_lo;
		end else begin
			if (wr_hi) res_hi_r <= wdata;
			if (wr_lo) res_lo_r <= wdata;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers and outputs
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_sync_r         <= 3'b000;
			rc_lvl_r          <= 1'b0;
			pin_s1_r          <= 8'h00;
			pin_s2_r          <= 8'h00;
			pin_s3_r          <= 8'h00;
			pin_lvl_r         <= 8'h00;
			port_rd_r         <= 8'h00;
			dac_code          <= 10'h000;
			channel_select    <= 3'b000;
			analog_power      <= 1'b0;
			acquire_en        <= 1'b0;
			pin_analog_config <= 8'hff;
			wake_req          <= 1'b0;
			irq_req           <= 1'b0;
		end else begin
			rc_sync_r <= {rc_sync_r[1:0], rc_clk};
			if (rc_sync_r[2] == rc_sync_r[1]) rc_lvl_r <= rc_sync_r[1];
			pin_s1_r  <= port_pins;
			pin_s2_r  <= pin_s1_r;
			pin_s3_r  <= pin_s2_r;
			pin_lvl_r <= (pin_lvl_r & (pin_s2_r ^ pin_s3_r)) | (pin_s2_r & pin_s3_r);
			port_rd_r <= port_read;
			dac_code  <= trial_r;
			channel_select <= ctrl_r[acs_pkg::CM_CHAN_HI:acs_pkg::CM_CHAN_LO];
			analog_power <= pwr_on && !down_r;
			acquire_en <= pwr_on && !down_r && !go_r;
			pin_analog_config <= analog_mask;
			wake_req <= stat_r[acs_pkg::ST_FLAG] && wake_en;
			irq_req  <= wake_req && stat_r[acs_pkg::ST_GLOB_IE];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [3:0] tick_seen_r;
	logic [6:0] gap_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_seen_r <= 4'h0;
			gap_r       <= 7'h00;
		end else begin
			if (start_req) tick_seen_r <= 4'h0;
			else if (go_r && tad_tick) tick_seen_r <= 4'(tick_seen_r + 4'd1);
			gap_r <= (tad_tick || start_req) ? 7'h00 : 7'(gap_r + 7'd1);
		end
	end

	sequence s_first_hold;
		(state_r == S_FIRST)[*4];
	endsequence

	property p_twelve_tads;
		done |-> (tick_seen_r >= 4'd11);
	endproperty
	a_twelve_tads: assert property (p_twelve_tads) else $error("conversion not 12 tads");

	property p_div_gap;
		(state_r == S_CONV) && tad_tick && !rc_sel && $stable(clk_sel) && (tad_cnt_r > 4'd1)
		|-> (7'(gap_r + 7'd1) == 7'(7'd2 << {clk_sel[1:0], clk_sel[2]}));
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("bit period not selected divide");

	property p_abort_keeps;
		abort_sw |=> !go_r && (state_r == S_IDLE) && $stable(res_hi_r) && $stable(res_lo_r);
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");

	property p_reacquire;
		abort_sw && wdata[acs_pkg::CM_PWR] && !sleep_mode ##1 !sleep_mode |=> acquire_en;
	endproperty
	a_reacquire: assert property (p_reacquire) else $error("no acquisition after abort");

	property p_first_min;
		start_req |=> s_first_hold;
	endproperty
	a_first_min: assert property (p_first_min) else $error("first segment too short");

	property p_justify;
		done |=> (justify ? (res_hi_r[7:2] == 6'h00) : (res_lo_r[5:0] == 6'h00));
	endproperty
	a_justify: assert property (p_justify) else $error("unused result bits not zero");

	property p_sleep_abort;
		go_r && sleep_mode && !rc_sel ##1 sleep_mode |-> !go_r ##1 !analog_power;
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

	property p_done_flag;
		done |=> !go_r && stat_r[acs_pkg::ST_FLAG];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

	property p_irq_gate;
		irq_req |-> $past(stat_r[acs_pkg::ST_FLAG], 2) && $past(stat_r[acs_pkg::ST_GLOB_IE]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without flag");

	property p_port_mask;
		##1 ((port_rd_r & pin_analog_config) == 8'h00);
	endproperty
	a_port_mask: assert property (p_port_mask) else $error("analog pin read high");
endmodule

// file: src/acs_pkg.sv
// Purpose: shared constants of the conversion sequencer
// Assumes: hclk is the oscillator (Tosc), 200 MHz
// Notes:   register byte address is four times the register index
package acs_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_RES_HIGH = 8'h1e;
	localparam logic [7:0] IDX_CONTROL  = 8'h1f;
	localparam logic [7:0] IDX_RES_LOW  = 8'h9e;
	localparam logic [7:0] IDX_FORMAT   = 8'h9f;
	localparam logic [7:0] IDX_STATUS   = 8'h20;
	localparam logic [7:0] IDX_PORT     = 8'h21;
	// ------------------------------------------------------------
	// conv_control_main fields
	// ------------------------------------------------------------
	localparam int CM_CLK_MID = 7;
	localparam int CM_CLK_LO  = 6;
	localparam int CM_CHAN_HI = 5;
	localparam int CM_CHAN_LO = 3;
	localparam int CM_GO      = 2;
	localparam int CM_PWR     = 0;
	// ------------------------------------------------------------
	// conv_format_pins fields
	// ------------------------------------------------------------
	localparam int FP_JUSTIFY = 7;
	localparam int FP_CLK_HI  = 6;
	localparam int FP_PCFG_HI = 3;
	// ------------------------------------------------------------
	// status / enable fields
	// ------------------------------------------------------------
	localparam int ST_FLAG    = 0;
	localparam int ST_DONE_IE = 1;
	localparam int ST_PERI_IE = 2;
	localparam int ST_GLOB_IE = 3;
	localparam int ST_POWERED = 4;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] FORMAT_RST  = 8'h00;
	localparam logic [3:0] STATUS_RST  = 4'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          RES_W        = 10;
	localparam logic [3:0]  TAD_LAST     = 4'd11;
	localparam int          TCY_OSC      = 4;
	localparam int          TCY_CYCLES   = TCY_OSC;
	localparam logic [2:0]  TCY_LAST     = 3'(TCY_CYCLES - 1);
	localparam logic [1:0]  SEL_RC       = 2'b11;
	localparam logic [9:0]  SAR_FIRST    = 10'h200;
endpackage

// file: src/acs_tad_gen.sv
// Purpose: per-bit conversion clock tick
// Assumes: rc_edge is already synchronised to hclk
// Notes:   divider phase restarts on restart
`timescale 1ns/1ps
module acs_tad_gen (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [2:0] sel,
	input  wire logic       rc_edge,
	input  wire logic       restart,
	output logic            tick
);
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [2:0] shift_amt;
	logic [5:0] lim;
	logic       rc_mode;
	logic       wrap;

	// select to divide ratio
	// code 000 -> 2, 100 -> 4, 001 -> 8, 101 -> 16, 010 -> 32, 110 -> 64
	assign shift_amt = {sel[1:0], sel[2]};
	assign lim       = 6'((7'd2 << shift_amt) - 7'd1);
	assign rc_mode   = (sel[1:0] == acs_pkg::SEL_RC);
	assign wrap      = (cnt_r == lim);
	assign cnt_nxt   = (restart || wrap) ? 6'h00 : 6'(cnt_r + 6'd1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 6'h00;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= rc_mode ? rc_edge : (wrap && !restart);
		end
	end
endmodule

// file: src/acs_pin_mask.sv
// Purpose: analog/digital pin map and masked port read
// Assumes: port levels are already synchronised
// Notes:   a set mask bit marks an analog or reference pin
`timescale 1ns/1ps
module acs_pin_mask (
	input  wire logic [3:0] pcfg,
	input  wire logic [7:0] port_lvl,
	output logic      [7:0] analog_mask,
	output logic      [7:0] port_read
);
	always_comb begin
		unique case (pcfg)
			4'h0, 4'h1, 4'h8:       analog_mask = 8'hff;
			4'h2, 4'h3, 4'hc:       analog_mask = 8'h1f;
			4'h4, 4'h5:             analog_mask = 8'h0b;
			4'h6, 4'h7:             analog_mask = 8'h00;
			4'h9, 4'ha, 4'hb:       analog_mask = 8'h3f;
			4'hd:                   analog_mask = 8'h0f;
			4'he:                   analog_mask = 8'h01;
			4'hf:                   analog_mask = 8'h0d;
		endcase
	end

	assign port_read = port_lvl & ~analog_mask;
endmodule

// file: verif/testbench.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: hclk is Tosc; comparator modelled from a target level
// Notes:   expected registers kept as integers in the bench
`timescale 1ns/1ps
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rc_clk;
	logic [7:0]  port_pins;
	logic        sleep_mode;
	logic        cmp_decision;
	logic [9:0]  dac_code;
	logic [2:0]  channel_select;
	logic        analog_power;
	logic        acquire_en;
	logic [7:0]  pin_analog_config;
	logic        wake_req;
	logic        irq_req;
	logic [9:0]  target;
	logic [31:0] rd;
	int          mismatches;
	int          check_count;
	int          cyc;
	int          seed;
	int          t0;
	int          res_hi;
	int          res_lo;
	logic [7:0]  amask [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
		8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
	logic [2:0]  sels [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
	int          ns [6] = '{2, 4, 8, 16, 32, 64};

	// comparator: input level at or above trial code
	assign cmp_decision = (target >= dac_code);

	acs_sequencer i_acs_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rc_clk(rc_clk),
		.port_pins(port_pins), .sleep_mode(sleep_mode), .cmp_decision(cmp_decision),
		.dac_code(dac_code), .channel_select(channel_select), .analog_power(analog_power),
		.acquire_en(acquire_en), .pin_analog_config(pin_analog_config),
		.wake_req(wake_req), .irq_req(irq_req));

	// ------------------------------------------------------------
	// clocks and timeout
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		rc_clk = 1'b0;
		#1.3;
		forever #18.5 rc_clk = ~rc_clk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// checks and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rng(input string n, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask
	function automatic logic [31:0] ra(input logic [7:0] i);
		return {22'h0, i, 2'b00};
	endfunction
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		t0 = cyc;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, ra(i), d);
	endtask
	task automatic rd_chk(input string n, input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, ra(i), 8'h00);
		chk(n, {24'h00_0000, e}, rd);
	endtask
	task automatic results;
		rd_chk("res high", acs_pkg::IDX_RES_HIGH, 8'(res_hi));
		rd_chk("res low", acs_pkg::IDX_RES_LOW, 8'(res_lo));
	endtask

	// ------------------------------------------------------------
	// one conversion with bench model of timing and result
	// ------------------------------------------------------------
	task automatic conv(input logic j, input logic [2:0] sel, input int lo, input int hi,
		input logic slp);
		int          tv;
		int          s;
		logic [2:0]  ch;
		tv = $random(seed) & 1023;
		ch = 3'($random(seed));
		target <= 10'(tv);
		wr(acs_pkg::IDX_FORMAT, {j, sel[2], 6'h00});
		wr(acs_pkg::IDX_STATUS, 8'h0e);
		wr(acs_pkg::IDX_CONTROL, {sel[1:0], ch, 3'h1});
		wr(acs_pkg::IDX_CONTROL, {sel[1:0], ch, 3'h5});
		s = t0;
		sleep_mode <= slp;
		while (wake_req !== 1'b1) @(posedge hclk);
		chk_rng("conv cycles", lo, hi, cyc - s);
		@(posedge hclk);
		chk("irq", 1, irq_req);
		sleep_mode <= 1'b0;
		res_hi = j ? tv >> 8 : tv >> 2;
		res_lo = j ? tv & 255 : (tv & 3) << 6;
		results();
		rd_chk("control", acs_pkg::IDX_CONTROL, {sel[1:0], ch, 3'h1});
		rd_chk("status", acs_pkg::IDX_STATUS, 8'h1f);
		chk("channel", ch, channel_select);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 67311;
		cyc = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		port_pins = 8'h00;
		sleep_mode = 1'b0;
		target = 10'h000;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("control rst", acs_pkg::IDX_CONTROL, 8'h00);
		rd_chk("format rst", acs_pkg::IDX_FORMAT, 8'h00);
		rd_chk("status rst", acs_pkg::IDX_STATUS, 8'h00);
		chk("pins rst", 8'hff, pin_analog_config);
		res_hi = $random(seed) & 255;
		res_lo = $random(seed) & 255;
		wr(acs_pkg::IDX_RES_HIGH, 8'(res_hi));
		wr(acs_pkg::IDX_RES_LOW, 8'(res_lo));
		results();
		bus(1'b0, 32'h0000_0478, 8'h00);
		chk("unmapped", 0, rd);
		chk("resp", 0, hresp);
		for (int p = 0; p < 16; p++) begin
			port_pins <= 8'($random(seed));
			wr(acs_pkg::IDX_FORMAT, {4'h0, 4'(p)});
			repeat (5) @(posedge hclk);
			chk("pin map", amask[p], pin_analog_config);
			rd_chk("port", acs_pkg::IDX_PORT, port_pins & ~amask[p]);
		end
		for (int i = 0; i < 6; i++) begin
			conv(1'(i), sels[i], 12 * ns[i], 12 * ns[i] + 6, 1'b0);
		end
		conv(1'b1, 3'h3, 80, 130, 1'b0);
		conv(1'b0, 3'h7, 80, 130, 1'b1);
		// flag without all enables
		wr(acs_pkg::IDX_STATUS, 8'h01);
		repeat (3) @(posedge hclk);
		chk("wake masked", 0, wake_req);
		wr(acs_pkg::IDX_STATUS, 8'h07);
		repeat (3) @(posedge hclk);
		chk("wake", 1, wake_req);
		chk("irq masked", 0, irq_req);
		// abort in mid conversion
		wr(acs_pkg::IDX_STATUS, 8'h0e);
		wr(acs_pkg::IDX_FORMAT, 8'h40);
		wr(acs_pkg::IDX_CONTROL, 8'h81);
		wr(acs_pkg::IDX_CONTROL, 8'h85);
		repeat (100) @(posedge hclk);
		wr(acs_pkg::IDX_CONTROL, 8'h81);
		repeat (3) @(posedge hclk);
		chk("acquire", 1, acquire_en);
		chk("abort wake", 0, wake_req);
		results();
		rd_chk("abort ctl", acs_pkg::IDX_CONTROL, 8'h81);
		conv(1'b1, 3'h6, 768, 774, 1'b0);
		// sleep with divided clock
		wr(acs_pkg::IDX_STATUS, 8'h0e);
		wr(acs_pkg::IDX_CONTROL, 8'h85);
		repeat (50) @(posedge hclk);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge hclk);
		chk("sleep power", 0, analog_power);
		rd_chk("sleep ctl", acs_pkg::IDX_CONTROL, 8'h81);
		sleep_mode <= 1'b0;
		repeat (4) @(posedge hclk);
		chk("wake power", 1, analog_power);
		chk("sleep wake", 0, wake_req);
		results();
		// rc conversion in sleep without wake enable
		wr(acs_pkg::IDX_STATUS, 8'h00);
		wr(acs_pkg::IDX_CONTROL, 8'hc1);
		wr(acs_pkg::IDX_CONTROL, 8'hc5);
		sleep_mode <= 1'b1;
		repeat (200) @(posedge hclk);
		chk("rc sleep power", 0, analog_power);
		chk("rc sleep wake", 0, wake_req);
		rd_chk("rc sleep ctl", acs_pkg::IDX_CONTROL, 8'hc1);
		rd_chk("rc sleep status", acs_pkg::IDX_STATUS, 8'h01);
		sleep_mode <= 1'b0;
		res_hi = target >> 8;
		res_lo = target & 255;
		results();
		// reset during a conversion
		wr(acs_pkg::IDX_CONTROL, 8'h85);
		repeat (30) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		chk("pins mid", 8'hff, pin_analog_config);
		chk("power mid", 0, analog_power);
		rd_chk("ctl mid", acs_pkg::IDX_CONTROL, 8'h00);
		results();
		finish_test();
	end
endmodule
